/* src/lin_slave_pkg.sv */
// Constants and types for the LIN slave header and divider block.
// Assumes a single 125 MHz APB clock; register indices map to byte
// addresses as index times four.
package lin_slave_pkg;

   // Register indices, byte address is four times the index
   localparam logic [7:0] STATUS_IDX = 8'h48;
   localparam logic [7:0] BAUD_IDX   = 8'h4A;
   localparam logic [7:0] CTRL3_IDX  = 8'h4D;
   localparam logic [7:0] ERPR_IDX   = 8'h4E;
   localparam logic [7:0] ETPR_IDX   = 8'h4F;

   // Reset and fixed read values
   localparam logic [7:0] STATUS_READ_VAL = 8'hC0;
   localparam logic [7:0] MANT_RESET      = 8'h00;
   localparam logic [3:0] FRAC_RESET      = 4'h0;
   localparam logic [7:0] HLEN_RESET      = 8'h00;
   localparam logic [7:0] HLEN_BREAK      = 8'hFF;
   localparam logic [7:0] HLEN_TIMEOUT    = 8'h00;

   // Control register three field positions
   localparam int CTRL3_UPDATE_POS = 7;
   localparam int CTRL3_LINE_POS   = 6;
   localparam int CTRL3_SLAVE_POS  = 5;
   localparam int CTRL3_ASYNC_POS  = 4;
   localparam int CTRL3_METHOD_POS = 3;
   localparam int CTRL3_HIE_POS    = 2;
   localparam int CTRL3_FLAG_POS   = 1;
   localparam int CTRL3_SYNC_POS   = 0;

   // Timing counts in bit times, quarter bits and sync falling edges
   localparam logic [3:0] BREAK_BITS      = 4'd11;
   localparam logic [7:0] BREAK_QUARTERS  = 8'd44;
   localparam logic [7:0] HEADER_MAX_Q    = 8'd228;
   localparam logic [3:0] CHAR_BITS       = 4'd10;
   localparam logic [2:0] SYNC_FALL_EDGES = 3'd5;

   // Control register three fields
   typedef struct packed {
      logic update_method;
      logic line_enable;
      logic slave_select;
      logic auto_sync_enable;
      logic header_detect_method;
      logic header_int_enable;
   } ctrl3_t;

   // Header tracking states, Gray from idle to the identifier bits
   typedef enum logic [2:0] {
      ST_IDLE    = 3'b000,
      ST_DELIM   = 3'b001,
      ST_SYNC    = 3'b011,
      ST_ID_WAIT = 3'b010,
      ST_ID_BITS = 3'b110
   } hdr_state_t;

endpackage : lin_slave_pkg

/* src/lin_slave_header_and_divider.sv */
// LIN slave header detection, sync field tracking and fractional divider.
// Assumes an APB master on pclk and a serial receive line synchronous
// to pclk.
`timescale 1ns/1ps
`default_nettype none
module lin_slave_header_and_divider
   import lin_slave_pkg::*;
#(
   parameter int ADDR_W = 12                   // APB address width
)(
   input  wire logic              pclk,                 // APB clock
   input  wire logic              presetn,              // Async reset, low
   input  wire logic [ADDR_W-1:0] paddr,                // APB address
   input  wire logic              psel,                 // APB select
   input  wire logic              penable,              // APB enable
   input  wire logic              pwrite,               // APB direction
   input  wire logic [31:0]       pwdata,               // APB write data
   input  wire logic [3:0]        pstrb,                // APB byte strobes
   output logic [31:0]            prdata,               // APB read data
   output logic                   pready,               // APB ready
   output logic                   pslverr,              // APB error
   input  wire logic              serial_rx_input,      // Serial line in
   output logic                   header_detected_flag, // Header seen
   output logic                   sync_field_state,     // In sync field
   output logic                   sci_clock_run,        // Tx/rx clocks on
   output logic [11:0]            baud_divider          // Divider, 1/16
);

   ctrl3_t       ctrl_reg;
   hdr_state_t   state_reg;
   logic [7:0]   mantissa_reg, header_length_reg, hdr_q_reg;
   logic [3:0]   fraction_reg, low_bits_reg, bits_reg;
   logic [11:0]  bit_cycles_reg;
   logic [31:0]  prdata_reg;
   logic [14:0]  meas_reg;
   logic [12:0]  acc_reg;
   logic [2:0]   edge_cnt_reg;
   logic [1:0]   qphase_reg;
   logic         flag_reg, sync_reg, status_seen_reg, clk_run_reg;
   logic         pready_reg, pslverr_reg, rx_prev_reg;

   logic         slave_mode, mapped, take, done, wr_en, rd_en;
   logic         hit_status, hit_baud, hit_ctrl3, hit_erpr, hit_etpr;
   logic [7:0]   rd_next, hdr_rounded;
   logic [12:0]  acc_sum;
   logic         qtick, btick, fall, in_header, round_up;
   logic         break_det, sw_clear_sync, sync_done, hdr_done, timeout;

   assign slave_mode = ctrl_reg.line_enable & ctrl_reg.slave_select;

   // Address decode, one aligned word per register
   always_comb
   begin
      logic addr_ok;
      addr_ok    = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
      hit_status = addr_ok && (paddr[9:2] == STATUS_IDX);
      hit_baud   = addr_ok && (paddr[9:2] == BAUD_IDX);
      hit_ctrl3  = addr_ok && (paddr[9:2] == CTRL3_IDX);
      hit_erpr   = addr_ok && (paddr[9:2] == ERPR_IDX);
      hit_etpr   = addr_ok && (paddr[9:2] == ETPR_IDX);
      mapped     = hit_status | hit_baud | hit_ctrl3 | hit_erpr | hit_etpr;
   end

   // Access phase handshake: one wait state, effects at the ready edge
   assign take  = psel & penable & ~pready_reg;
   assign done  = psel & penable & pready_reg;
   assign wr_en = done & pwrite & pstrb[0] & mapped;
   assign rd_en = done & ~pwrite;

   // Read data selection
   always_comb
   begin
      rd_next = 8'h00;
      if (hit_status)
         rd_next = STATUS_READ_VAL;
      else if (hit_baud)
         rd_next = slave_mode ? mantissa_reg : 8'h00;
      else if (hit_ctrl3)
         rd_next = {ctrl_reg, flag_reg, sync_reg};
      else if (hit_erpr && slave_mode &&
               (ctrl_reg.auto_sync_enable || ctrl_reg.header_detect_method))
         rd_next = header_length_reg;
      else if (hit_etpr && slave_mode)
         rd_next = {4'h0, fraction_reg};
   end

   // APB answer registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h0000_0000;
      end
      else
      begin
         pready_reg  <= take;
         pslverr_reg <= take & ~mapped;
         if (take && !pwrite)
            prdata_reg <= {24'h00_0000, rd_next};
      end
   end

   // Control register three fields written by software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_reg <= '0;
      else if (wr_en && hit_ctrl3)
         ctrl_reg <= pwdata[CTRL3_UPDATE_POS:CTRL3_HIE_POS];
   end

   // Divider registers and applied divider
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mantissa_reg   <= MANT_RESET;
         fraction_reg   <= FRAC_RESET;
         bit_cycles_reg <= 12'h000;
      end
      else
      begin
         if (wr_en && hit_etpr && slave_mode)
            fraction_reg <= pwdata[3:0];
         if (wr_en && hit_baud && slave_mode)
            mantissa_reg <= pwdata[7:0];
         if (sync_done && ctrl_reg.auto_sync_enable)
            bit_cycles_reg <= 12'((meas_reg + 15'd1) >> 3);
         else if (wr_en && hit_baud && slave_mode)
            bit_cycles_reg <= {pwdata[7:0], fraction_reg};
      end
   end

   // Tx and rx clocks run only with a nonzero mantissa
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         clk_run_reg <= 1'b0;
      else
         clk_run_reg <= slave_mode && (mantissa_reg != 8'h00);
   end

   // Quarter-bit phase accumulator, bit time is 16*mantissa+fraction
   assign acc_sum = acc_reg + 13'd4;
   assign qtick   = clk_run_reg && (bit_cycles_reg != 12'h000) &&
                    (acc_sum >= {1'b0, bit_cycles_reg});
   assign btick   = qtick && (qphase_reg == 2'd3);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         acc_reg    <= 13'h0000;
         qphase_reg <= 2'd0;
      end
      else if (!clk_run_reg)
      begin
         acc_reg    <= 13'h0000;
         qphase_reg <= 2'd0;
      end
      else if (qtick)
      begin
         acc_reg    <= acc_sum - {1'b0, bit_cycles_reg};
         qphase_reg <= qphase_reg + 2'd1;
      end
      else
         acc_reg <= acc_sum;
   end

   // Break detection: eleven dominant bit times
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         low_bits_reg <= 4'd0;
         rx_prev_reg  <= 1'b1;
      end
      else
      begin
         rx_prev_reg <= serial_rx_input;
         if (serial_rx_input || !clk_run_reg)
            low_bits_reg <= 4'd0;
         else if (btick && low_bits_reg < BREAK_BITS)
            low_bits_reg <= low_bits_reg + 4'd1;
      end
   end

   assign fall      = rx_prev_reg & ~serial_rx_input;
   assign break_det = btick && !serial_rx_input &&
                      (low_bits_reg == BREAK_BITS - 4'd1);
   assign sw_clear_sync = wr_en && hit_ctrl3 && !pwdata[CTRL3_SYNC_POS] &&
                          sync_reg;
   assign in_header = (state_reg != ST_IDLE);
   assign timeout   = in_header && qtick &&
                      (hdr_q_reg == HEADER_MAX_Q - 8'd1);

   // Sync field ends at fifth falling edge or after one character
   always_comb
   begin
      sync_done = 1'b0;
      if (state_reg == ST_SYNC)
      begin
         if (ctrl_reg.auto_sync_enable)
            sync_done = fall && (edge_cnt_reg == SYNC_FALL_EDGES - 3'd1);
         else
            sync_done = btick && (edge_cnt_reg != 3'd0) &&
                        (bits_reg == CHAR_BITS - 4'd1);
      end
   end

   assign hdr_done = (state_reg == ST_ID_BITS) && btick &&
                     (bits_reg == CHAR_BITS - 4'd1);

   // Header tracking state machine
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_reg <= ST_IDLE;
      else if (!slave_mode)
         state_reg <= ST_IDLE;
      else if (break_det)
         state_reg <= ST_DELIM;
      else if (sw_clear_sync || timeout)
         state_reg <= ST_IDLE;
      else
         case (state_reg)
            ST_IDLE:    state_reg <= ST_IDLE;
            ST_DELIM:   if (serial_rx_input) state_reg <= ST_SYNC;
            ST_SYNC:    if (sync_done) state_reg <= ST_ID_WAIT;
            ST_ID_WAIT: if (fall) state_reg <= ST_ID_BITS;
            ST_ID_BITS: if (hdr_done) state_reg <= ST_IDLE;
            default:    state_reg <= ST_IDLE;
         endcase
   end

   // Edge, cycle and bit counters for sync and identifier fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         edge_cnt_reg <= 3'd0;
         meas_reg     <= 15'h0000;
         bits_reg     <= 4'd0;
      end
      else if (state_reg == ST_SYNC)
      begin
         if (fall && edge_cnt_reg != SYNC_FALL_EDGES)
            edge_cnt_reg <= edge_cnt_reg + 3'd1;
         if (edge_cnt_reg != 3'd0)
            meas_reg <= meas_reg + 15'd1;
         if (btick && edge_cnt_reg != 3'd0)
            bits_reg <= bits_reg + 4'd1;
      end
      else if (state_reg == ST_ID_BITS)
      begin
         if (btick)
            bits_reg <= bits_reg + 4'd1;
      end
      else
      begin
         edge_cnt_reg <= 3'd0;
         meas_reg     <= 15'h0000;
         bits_reg     <= 4'd0;
      end
   end

   // Header duration in quarter bits, break counted from its start
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hdr_q_reg <= 8'd0;
      else if (break_det)
         hdr_q_reg <= BREAK_QUARTERS;
      else if (in_header && qtick)
         hdr_q_reg <= hdr_q_reg + 8'd1;
   end

   // Residue of half a quarter or more rounds up, carry is natural
   assign round_up    = ({acc_reg, 1'b0} >= {2'b00, bit_cycles_reg});
   assign hdr_rounded = hdr_q_reg + {7'd0, round_up};

   // Header length register, hardware updates only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         header_length_reg <= HLEN_RESET;
      else if (break_det)
         header_length_reg <= HLEN_BREAK;
      else if (timeout)
         header_length_reg <= HLEN_TIMEOUT;
      else if (hdr_done)
         header_length_reg <= HEADER_MAX_Q - hdr_rounded;
   end

   // Header flag: set wins over the status-then-control clear sequence
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         flag_reg        <= 1'b0;
         status_seen_reg <= 1'b0;
      end
      else
      begin
         if (done && hit_status)
            status_seen_reg <= 1'b1;
         else if (rd_en && hit_ctrl3)
            status_seen_reg <= 1'b0;
         if ((break_det && !ctrl_reg.header_detect_method) ||
             (hdr_done && ctrl_reg.header_detect_method))
            flag_reg <= 1'b1;
         else if (rd_en && hit_ctrl3 && status_seen_reg)
            flag_reg <= 1'b0;
      end
   end

   // Sync field state bit: set at break, cleared at end or by software
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         sync_reg <= 1'b0;
      else if (break_det)
         sync_reg <= 1'b1;
      else if (sync_done || timeout || sw_clear_sync || !slave_mode)
         sync_reg <= 1'b0;
   end

   // Outputs straight from flip-flops
   assign prdata               = prdata_reg;
   assign pready               = pready_reg;
   assign pslverr              = pslverr_reg;
   assign header_detected_flag = flag_reg;
   assign sync_field_state     = sync_reg;
   assign sci_clock_run        = clk_run_reg;
   assign baud_divider         = bit_cycles_reg;

   // Checks
   default clocking chk_clk @(posedge pclk); endclocking
   default disable iff (!presetn);

   break_length_a: assert property (break_det |=> header_length_reg == 8'hFF)
      else $error("break did not load FFh");
   timeout_length_a: assert property (timeout && !break_det |=>
      header_length_reg == 8'h00)
      else $error("timeout did not load 00h");
   done_length_a: assert property (hdr_done && !break_det |=>
      header_length_reg == 8'(HEADER_MAX_Q - $past(hdr_rounded)))
      else $error("header length not encoded");
   method_zero_a: assert property (break_det && !ctrl_reg.header_detect_method
      |=> flag_reg && sync_reg)
      else $error("break did not flag header");
   method_one_a: assert property (ctrl_reg.header_detect_method && !flag_reg &&
      !hdr_done |=> !flag_reg)
      else $error("flag set without identifier");
   flag_clear_a: assert property (rd_en && hit_ctrl3 && status_seen_reg &&
      !break_det && !hdr_done |=> !flag_reg)
      else $error("flag not cleared by sequence");
   flag_hold_a: assert property (flag_reg && !(rd_en && hit_ctrl3) |=> flag_reg)
      else $error("flag cleared early");
   sw_exit_a: assert property (sw_clear_sync && !break_det |=>
      state_reg == ST_IDLE && !sync_reg)
      else $error("software clear ignored");
   clock_stop_a: assert property (mantissa_reg == 8'h00 ##1
      mantissa_reg == 8'h00 |-> !sci_clock_run && !qtick)
      else $error("clocks run with zero mantissa");
   mant_apply_a: assert property (wr_en && hit_baud && slave_mode &&
      !sync_done |=> baud_divider == {$past(pwdata[7:0]), fraction_reg})
      else $error("divider not applied on write");
   frac_only_a: assert property ($changed(fraction_reg) |=>
      $stable(baud_divider) || $past(sync_done) ||
      $past(wr_en && hit_baud))
      else $error("fraction write changed divider");
   mode_gate_a: assert property (!slave_mode |=> state_reg == ST_IDLE)
      else $error("header logic active outside slave");

   break_seen_c: cover property (break_det ##[1:1000] sync_done);
   header_done_c: cover property (hdr_done && ctrl_reg.header_detect_method);
   timeout_c: cover property (timeout);
   flag_clear_c: cover property (flag_reg ##1 !flag_reg);

endmodule : lin_slave_header_and_divider
`default_nettype wire

/* test/lin_master_model.sv */
// LIN master model that drives the serial receive line of the slave.
// Assumes the bench calls its tasks just after a rising pclk edge.
`timescale 1ns/1ps
`default_nettype none
module lin_master_model #(
   parameter int BIT_CYC = 16              // Clock cycles per bit
)(
   input  wire logic pclk,                 // Bench clock
   output logic      rx                    // Serial line, recessive high
);
   // Line idles recessive, as its pull-up leaves it between frames
   initial rx = 1'b1;

   // Hold one level for a whole number of bit times
   task automatic hold_bits(input logic lvl, input int n);
      begin
         rx <= lvl;
         repeat (n * BIT_CYC) @(posedge pclk);
      end
   endtask : hold_bits

   // Start bit, eight data bits low first, stop bit
   task automatic send_byte(input logic [7:0] b);
      begin
         hold_bits(1'b0, 1);
         for (int i = 0; i < 8; i++) hold_bits(b[i], 1);
         hold_bits(1'b1, 1);
      end
   endtask : send_byte
endmodule : lin_master_model
`default_nettype wire

/* test/lin_slave_header_and_divider_bench.sv */
// Self-checking bench for the LIN slave header and divider block.
// Assumes the design package is compiled first; master model drives rx.
`timescale 1ns/1ps
`default_nettype none
module lin_slave_header_and_divider_bench;
   import lin_slave_pkg::*;
   localparam logic [11:0] A_ST = {2'b00, STATUS_IDX, 2'b00};
   localparam logic [11:0] A_BD = {2'b00, BAUD_IDX, 2'b00};
   localparam logic [11:0] A_C3 = {2'b00, CTRL3_IDX, 2'b00};
   localparam logic [11:0] A_ER = {2'b00, ERPR_IDX, 2'b00};
   localparam logic [11:0] A_ET = {2'b00, ETPR_IDX, 2'b00};
   typedef struct packed {
      logic wr; logic [11:0] a; logic [7:0] d; logic [7:0] x; logic e;
   } row_t;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, rx, flag, sync, run;
   logic [11:0] div;
   logic [7:0]  q, v;
   logic        e;
   int          n_fail = 0;
   int          checks_done = 0;
   int          cycles = 0;
   row_t        rows [10] = '{
      '{1'b0, A_ET, 8'h00, 8'h00, 1'b0},
      '{1'b1, A_C3, 8'h60, 8'h00, 1'b0},
      '{1'b0, A_C3, 8'h00, 8'h60, 1'b0},
      '{1'b0, A_BD, 8'h00, 8'h00, 1'b0},
      '{1'b1, A_ET, 8'hFA, 8'h00, 1'b0},
      '{1'b0, A_ET, 8'h00, 8'h0A, 1'b0},
      '{1'b1, A_BD, 8'hFF, 8'h00, 1'b0},
      '{1'b0, A_BD, 8'h00, 8'hFF, 1'b0},
      '{1'b0, A_ER, 8'h00, 8'h00, 1'b0},
      '{1'b0, 12'h000, 8'h00, 8'h00, 1'b1} // Unmapped word
   };

   // Clock of 8 ns
   always #4 pclk = ~pclk;

   lin_slave_header_and_divider uut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .serial_rx_input(rx), .header_detected_flag(flag),
      .sync_field_state(sync), .sci_clock_run(run), .baud_divider(div));

   lin_master_model #(.BIT_CYC(16)) master (.pclk(pclk), .rx(rx));

   task automatic chk(input logic [31:0] got, exp, input string what);
      begin
         checks_done++;
         if (got !== exp)
         begin
            n_fail++;
            $display("wrong value at %0t: %s got %h", $time, what, got);
         end
      end
   endtask : chk

   // Whole-register APB transfer; waits for pready, bounded
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [7:0] d, output logic [7:0] rd,
                      output logic err);
      int n;
      begin
         n = 0;
         psel    <= 1'b1;
         pwrite  <= wr;
         paddr   <= a;
         pwdata  <= {24'h0, d};
         @(posedge pclk);
         penable <= 1'b1;
         do begin @(posedge pclk); n++; end
         while (pready !== 1'b1 && n < 40);
         rd = prdata[7:0];
         err = pslverr;
         chk(n < 40, 1, "apb wait");
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic done_test(input string name);
      $display("test %s done", name);
   endtask : done_test

   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   // Hang guard
   always @(posedge pclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i])
      begin
         apb(rows[i].wr, rows[i].a, rows[i].d, q, e);
         chk(e, rows[i].e, "slverr");
         if (!rows[i].wr) chk(q, rows[i].x, "read");
      end
      done_test("rows");
      chk(div, 12'hFFA, "divider max");
      wr(A_ET, 8'h00);
      chk(div, 12'hFFA, "before mantissa");
      wr(A_BD, 8'h00);
      @(posedge pclk);
      chk(run, 0, "clock stop");
      wr(A_BD, 8'h01);
      @(posedge pclk);
      chk(div, 12'h010, "divider applied");
      chk(run, 1, "clock run");
      done_test("divider");
      master.hold_bits(1'b0, 13);
      master.hold_bits(1'b1, 1);
      chk(flag, 1, "break flag");
      chk(sync, 1, "sync set");
      apb(1'b0, A_ER, 8'h00, q, e);
      chk(q, 8'h00, "length hidden");
      apb(1'b0, A_C3, 8'h00, q, e);
      chk(flag, 1, "flag without status");
      apb(1'b0, A_ST, 8'h00, q, e);
      apb(1'b0, A_C3, 8'h00, q, e);
      chk(flag, 0, "flag cleared");
      wr(A_C3, 8'h60);
      chk(sync, 0, "sync cleared");
      done_test("method zero");
      wr(A_C3, 8'h78);
      master.hold_bits(1'b0, 13);
      chk(flag, 0, "no flag at break");
      apb(1'b0, A_ER, 8'h00, q, e);
      chk(q, 8'hFF, "length at break");
      master.hold_bits(1'b1, 1);
      master.send_byte(8'h55);
      chk(sync, 0, "sync done");
      chk(div, 12'h010, "auto divider");
      master.hold_bits(1'b1, 2);
      master.send_byte(8'h3C);
      master.hold_bits(1'b1, 1);
      chk(flag, 1, "header flag");
      apb(1'b0, A_ER, 8'h00, v, e);
      chk(v >= 8'h48 && v <= 8'h5C, 1, "length");
      wr(A_ER, 8'h00);
      apb(1'b0, A_ER, 8'h00, q, e);
      chk(q, v, "length read only");
      wr(A_C3, 8'h70);
      apb(1'b0, A_ER, 8'h00, q, e);
      chk(q, v, "length with auto");
      done_test("method one");
      wr(A_C3, 8'h78);
      master.hold_bits(1'b0, 13);
      master.hold_bits(1'b1, 50);
      apb(1'b0, A_ER, 8'h00, q, e);
      chk(q, 8'h00, "timeout length");
      done_test("timeout");
      wr(A_C3, 8'h40);
      master.hold_bits(1'b0, 13);
      master.hold_bits(1'b1, 1);
      chk(sync, 0, "no sync off slave");
      apb(1'b0, A_BD, 8'h00, q, e);
      chk(q, 8'h00, "baud hidden");
      done_test("mode off");
      chk(flag, 1, "flag before reset");
      presetn <= 1'b0;
      @(posedge pclk);
      chk(flag, 0, "flag after reset");
      chk(div, 12'h000, "divider after reset");
      chk(run, 0, "clock after reset");
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, A_C3, 8'h00, q, e);
      chk(q, 8'h00, "control after reset");
      done_test("reset");
      tally_and_finish();
   end
endmodule : lin_slave_header_and_divider_bench
`default_nettype wire
